// ==== verification/swp_pin_env.sv ====
// Board model of the protect/hold pins with pull-ups
`timescale 1ns/1ps
module swp_pin_env (
  input  wire logic wp_drv,
  input  wire logic wp_lvl,
  input  wire logic hold_drv,
  input  wire logic hold_lvl,
  input  wire logic dl2_out,
  input  wire logic dl2_oe_n,
  input  wire logic dl3_out,
  input  wire logic dl3_oe_n,
  output logic      dl2_in,
  output logic      dl3_in
);
  // Both driving shows as unknown; a released line floats to the pull-up
  function automatic logic lvl(logic de, logic dv, logic he, logic hv);
    if (de && he) return 1'bx;
    if (de) return dv;
    if (he) return hv;
    return 1'b1;
  endfunction
  assign dl2_in = lvl(!dl2_oe_n, dl2_out, wp_drv, wp_lvl);
  assign dl3_in = lvl(!dl3_oe_n, dl3_out, hold_drv, hold_lvl);
endmodule

// ==== verification/swp_top_test.sv ====
// Self-checking bench for the status write-protect block
`timescale 1ns/1ps
module swp_top_test import swp_pkg::*; ();
  logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, quad_doe;
  logic        dl2_in, dl2_out, dl2_oe_n, dl3_in, dl3_out, dl3_oe_n;
  logic        hold_active, quad_mode, wp_drv, wp_lvl, hold_drv, hold_lvl;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd, exp_sr;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, quad_dout;
  logic [2:0]  sec_lock, sec_prog;
  int          num_errors, checks_done;
  int          prog_hits_ff[3] = '{0, 0, 0};

  swp_top i_dut (
    .clk(clk), .rstn(rstn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .dl2_in(dl2_in), .dl2_out(dl2_out), .dl2_oe_n(dl2_oe_n),
    .dl3_in(dl3_in), .dl3_out(dl3_out), .dl3_oe_n(dl3_oe_n),
    .quad_dout(quad_dout), .quad_doe(quad_doe),
    .hold_active(hold_active), .quad_mode(quad_mode),
    .sec_lock(sec_lock), .sec_prog(sec_prog));

  swp_pin_env i_env (
    .wp_drv(wp_drv), .wp_lvl(wp_lvl), .hold_drv(hold_drv),
    .hold_lvl(hold_lvl), .dl2_out(dl2_out), .dl2_oe_n(dl2_oe_n),
    .dl3_out(dl3_out), .dl3_oe_n(dl3_oe_n), .dl2_in(dl2_in),
    .dl3_in(dl3_in));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Counting every cycle catches a grant pulse that lasts too long
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (sec_prog[i]) prog_hits_ff[i] <= prog_hits_ff[i] + 1;
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int n;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    check("wr_answer", {31'h0, n < 40}, 32'h1);
    check("bresp", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        input logic [1:0] er);
    int n;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    d = rdata;
    check("rd_answer", {31'h0, n < 40}, 32'h1);
    check("rresp", {30'h0, rresp}, {30'h0, er});
  endtask

  task automatic sr_cmp(input logic [31:0] m);
    axi_rd(SWP_STAT_OFS, rd, SWP_RESP_OKAY);
    check("sr_fields", rd & m, exp_sr);
    check("quad_mode", {31'h0, quad_mode}, {31'h0, exp_sr[9]});
    check("sec_lock", {29'h0, sec_lock}, {29'h0, exp_sr[13:11]});
  endtask

  // Latch set, status write, then result flag and readback
  task automatic sr_try(input logic [31:0] d, input logic acc);
    axi_wr(SWP_CMD_OFS, 32'h1, SWP_RESP_OKAY);
    axi_wr(SWP_STAT_OFS, d, SWP_RESP_OKAY);
    axi_rd(SWP_EVT_OFS, rd, SWP_RESP_OKAY);
    check("sr_result", {30'h0, rd[1:0]}, acc ? 32'h2 : 32'h1);
    if (acc) begin
      exp_sr[9:7]   = d[9:7];
      exp_sr[13:11] = exp_sr[13:11] | d[13:11];
    end
    sr_cmp(acc ? 32'h3B82 : 32'h3B80);
  endtask

  task automatic sec_try(input logic [1:0] r, input logic acc);
    int h[3];
    h = prog_hits_ff;
    axi_wr(SWP_CMD_OFS, 32'h1, SWP_RESP_OKAY);
    axi_wr(SWP_SEC_OFS, {30'h0, r}, SWP_RESP_OKAY);
    repeat (3) @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      check("prog_pulses", prog_hits_ff[i] - h[i],
            (acc && r == i + 1) ? 32'h1 : 32'h0);
    end
    axi_rd(SWP_EVT_OFS, rd, SWP_RESP_OKAY);
    check("sec_result", {30'h0, rd[3:2]}, acc ? 32'h2 : 32'h1);
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clk);
    num_errors++;
    $display("ERROR watchdog expected finish seen hang");
    end_sim;
  end

  initial begin
    rstn      = 1'b0;
    awvalid   = 1'b0;
    wvalid    = 1'b0;
    bready    = 1'b0;
    arvalid   = 1'b0;
    rready    = 1'b0;
    awaddr    = 8'h00;
    araddr    = 8'h00;
    wdata     = 32'h0;
    wstrb     = 4'hF;
    quad_dout = 2'h0;
    quad_doe  = 1'b0;
    wp_drv    = 1'b1;
    wp_lvl    = 1'b1;
    hold_drv  = 1'b1;
    hold_lvl  = 1'b1;
    exp_sr    = 32'h0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    check("oe_n", {30'h0, dl2_oe_n, dl3_oe_n}, 32'h3);
    sr_cmp(32'h3B82);
    axi_rd(8'h10, rd, SWP_RESP_SLVERR);
    check("unmapped_rd", rd, 32'h0);
    axi_wr(8'h10, 32'hFFFF, SWP_RESP_SLVERR);
    $display("test reset done");
    axi_wr(SWP_CMD_OFS, 32'h2, SWP_RESP_OKAY);
    axi_wr(SWP_STAT_OFS, 32'h0800, SWP_RESP_OKAY);
    axi_rd(SWP_EVT_OFS, rd, SWP_RESP_OKAY);
    check("no_latch", {30'h0, rd[1:0]}, 32'h1);
    sr_cmp(32'h3B82);
    wp_lvl <= 1'b0;
    sr_try(32'h0800, 1'b1);
    sec_try(2'h1, 1'b0);
    sec_try(2'h2, 1'b1);
    sec_try(2'h0, 1'b0);
    sr_try(32'h0000, 1'b1);
    $display("test locks done");
    sr_try(32'h0080, 1'b1);
    axi_rd(SWP_EVT_OFS, rd, SWP_RESP_OKAY);
    check("wp_level", {31'h0, rd[4]}, 32'h0);
    sr_try(32'h2080, 1'b0);
    wp_lvl <= 1'b1;
    sr_try(32'h2080, 1'b1);
    $display("test hw protect done");
    hold_lvl <= 1'b0;
    repeat (3) @(posedge clk);
    check("hold_on", {31'h0, hold_active}, 32'h1);
    // Release strapped pins before quad enable is set
    wp_drv   <= 1'b0;
    hold_drv <= 1'b0;
    sr_try(32'h2280, 1'b1);
    hold_drv <= 1'b1;
    wp_drv   <= 1'b1;
    wp_lvl   <= 1'b0;
    repeat (3) @(posedge clk);
    check("hold_off", {31'h0, hold_active}, 32'h0);
    sr_try(32'h2280, 1'b1);
    wp_drv    <= 1'b0;
    hold_drv  <= 1'b0;
    quad_dout <= 2'h2;
    quad_doe  <= 1'b1;
    repeat (3) @(posedge clk);
    check("quad_pins", {28'h0, dl2_oe_n, dl3_oe_n, dl2_out, dl3_out},
          32'h1);
    sr_try(32'h0080, 1'b1);
    repeat (3) @(posedge clk);
    check("pins_idle", {30'h0, dl2_oe_n, dl3_oe_n}, 32'h3);
    quad_doe <= 1'b0;
    wp_drv   <= 1'b1;
    wp_lvl   <= 1'b1;
    hold_drv <= 1'b1;
    hold_lvl <= 1'b1;
    $display("test quad done");
    sr_try(32'h0100, 1'b1);
    sr_try(32'h0000, 1'b0);
    axi_wr(SWP_CMD_OFS, 32'h4, SWP_RESP_OKAY);
    exp_sr[8:7] = 2'h0;
    sr_cmp(32'h3B80);
    sr_try(32'h0180, 1'b1);
    sr_try(32'h0000, 1'b0);
    axi_wr(SWP_CMD_OFS, 32'h4, SWP_RESP_OKAY);
    sr_cmp(32'h3B80);
    sr_try(32'h0080, 1'b0);
    $display("test lockdown done");
    end_sim;
  end
endmodule

// ==== verilog/swp_axil.sv ====
// AXI4-Lite slave front end for the write-protect registers
`timescale 1ns/1ps
module swp_axil import swp_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        awvalid,
  output logic             awready_ff,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready_ff,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid_ff,
  input  wire logic        bready,
  output logic [1:0]       bresp_ff,
  input  wire logic        arvalid,
  output logic             arready_ff,
  input  wire logic [7:0]  araddr,
  output logic             rvalid_ff,
  input  wire logic        rready,
  output logic [31:0]      rdata_ff,
  output logic [1:0]       rresp_ff,
  swp_regbus_if.bus        rb
);
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic [7:0]  araddr_ff;
  logic        fire;
  logic        rd_pend;

  // Ready low means the slot holds a beat
  assign fire    = !awready_ff && !wready_ff && !bvalid_ff;
  assign rd_pend = !arready_ff && !rvalid_ff;
  assign rb.wr_stb  = fire;
  assign rb.wr_addr = awaddr_ff;
  assign rb.wr_data = wdata_ff;
  assign rb.rd_addr = araddr_ff;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      awready_ff <= 1'b1;
      awaddr_ff  <= 8'h00;
    end else if (awvalid && awready_ff) begin
      awready_ff <= 1'b0;
      awaddr_ff  <= awaddr;
    end else if (bvalid_ff && bready) begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wready_ff <= 1'b1;
      wdata_ff  <= 32'h0000_0000;
    end else if (wvalid && wready_ff) begin
      wready_ff <= 1'b0;
      wdata_ff  <= wdata & {{8{wstrb[3]}}, {8{wstrb[2]}},
                            {8{wstrb[1]}}, {8{wstrb[0]}}};
    end else if (bvalid_ff && bready) begin
      wready_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= SWP_RESP_OKAY;
    end else if (fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= swp_addr_ok(awaddr_ff) ? SWP_RESP_OKAY : SWP_RESP_SLVERR;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      arready_ff <= 1'b1;
      araddr_ff  <= 8'h00;
    end else if (arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      araddr_ff  <= araddr;
    end else if (rvalid_ff && rready) begin
      arready_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= SWP_RESP_OKAY;
    end else if (rd_pend) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rb.rd_data;
      rresp_ff  <= swp_addr_ok(araddr_ff) ? SWP_RESP_OKAY : SWP_RESP_SLVERR;
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end
endmodule

// ==== verilog/swp_pin_mux.sv ====
// Function select of the shared protect/hold/data pins
`timescale 1ns/1ps
module swp_pin_mux import swp_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       qe,
  input  wire logic       dl2_in,
  input  wire logic       dl3_in,
  input  wire logic [1:0] quad_dout,
  input  wire logic       quad_doe,
  output logic            wp_level_ff,
  output logic            hold_active_ff,
  output logic            dl2_out_ff,
  output logic            dl3_out_ff,
  output logic            dl2_oe_n_ff,
  output logic            dl3_oe_n_ff
);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wp_level_ff    <= 1'b1;
      hold_active_ff <= 1'b0;
    end else begin
      // In quad mode the protect pin no longer guards anything
      wp_level_ff    <= qe ? 1'b1 : dl2_in;
      hold_active_ff <= !qe && !dl3_in;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      dl2_out_ff  <= 1'b0;
      dl3_out_ff  <= 1'b0;
      dl2_oe_n_ff <= 1'b1;
      dl3_oe_n_ff <= 1'b1;
    end else begin
      dl2_out_ff  <= qe && quad_dout[0];
      dl3_out_ff  <= qe && quad_dout[1];
      dl2_oe_n_ff <= !(qe && quad_doe);
      dl3_oe_n_ff <= !(qe && quad_doe);
    end
  end
endmodule

// ==== verilog/swp_pkg.sv ====
// Constants, types and helpers shared by the status write-protect block
package swp_pkg;
  localparam logic [7:0] SWP_CMD_OFS  = 8'h00;
  localparam logic [7:0] SWP_STAT_OFS = 8'h04;
  localparam logic [7:0] SWP_EVT_OFS  = 8'h08;
  localparam logic [7:0] SWP_SEC_OFS  = 8'h0C;
  localparam int SWP_CMD_SET_WEL = 0;
  localparam int SWP_CMD_CLR_WEL = 1;
  localparam int SWP_CMD_PWR_CYC = 2;
  localparam int SWP_WEL_BIT     = 1;
  localparam int SWP_PM_LO_BIT   = 7;
  localparam int SWP_PM_HI_BIT   = 8;
  localparam int SWP_QE_BIT      = 9;
  localparam int SWP_LOCK_LSB    = 11;
  localparam int SWP_LOCK_MSB    = 13;
  localparam int SWP_EVT_SR_REJ  = 0;
  localparam int SWP_EVT_SR_ACC  = 1;
  localparam int SWP_EVT_SEC_REJ = 2;
  localparam int SWP_EVT_SEC_ACC = 3;
  localparam int SWP_EVT_WP_LVL  = 4;
  localparam logic [1:0] SWP_PM_RST   = 2'h0;
  localparam logic       SWP_QE_RST   = 1'h0;
  localparam logic [2:0] SWP_LOCK_RST = 3'h0;
  localparam logic [1:0] SWP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SWP_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SWP_PM_SOFT     = 2'h0,
    SWP_PM_HW       = 2'h1,
    SWP_PM_OTP      = 2'h3,
    SWP_PM_LOCKDOWN = 2'h2
  } swp_pmode_t;

  function automatic logic swp_addr_ok(input logic [7:0] a);
    return a == SWP_CMD_OFS || a == SWP_STAT_OFS ||
           a == SWP_EVT_OFS || a == SWP_SEC_OFS;
  endfunction

  function automatic logic swp_sr_write_ok(input swp_pmode_t pm,
                                           input logic write_enable_latch,
                                           input logic wp_lvl);
    logic ok;
    unique case (pm)
      SWP_PM_SOFT:     ok = write_enable_latch;
      SWP_PM_HW:       ok = write_enable_latch && wp_lvl;
      SWP_PM_LOCKDOWN: ok = 1'b0;
      SWP_PM_OTP:      ok = 1'b0;
    endcase
    return ok;
  endfunction
endpackage

// ==== verilog/swp_regbus_if.sv ====
// Internal register access path between bus slave and core
`timescale 1ns/1ps
interface swp_regbus_if;
  logic        wr_stb;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  modport bus  (output wr_stb, wr_addr, wr_data, rd_addr, input rd_data);
  modport core (input wr_stb, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

// ==== verilog/swp_top.sv ====
// Status register write protection, quad enable and security locks
`timescale 1ns/1ps
module swp_top import swp_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        dl2_in,
  output logic             dl2_out,
  output logic             dl2_oe_n,
  input  wire logic        dl3_in,
  output logic             dl3_out,
  output logic             dl3_oe_n,
  input  wire logic [1:0]  quad_dout,
  input  wire logic        quad_doe,
  output logic             hold_active,
  output logic             quad_mode,
  output logic [2:0]       sec_lock,
  output logic [2:0]       sec_prog
);
  swp_regbus_if rb_if ();

  logic       wel_ff;
  logic       pm_lo_ff;
  logic       pm_hi_ff;
  logic       qe_ff;
  logic [2:0] lock_ff;
  logic [2:0] sec_prog_ff;
  logic       sr_rej_ff;
  logic       sr_acc_ff;
  logic       sec_rej_ff;
  logic       sec_acc_ff;
  logic       wp_level;

  swp_pmode_t pmode;
  logic       cmd_wr;
  logic       stat_wr;
  logic       sec_wr;
  logic       pwr_cycle;
  logic       sr_ok;
  logic [1:0] sec_idx;
  logic       sec_hit;
  logic       sec_ok;
  logic [2:0] sec_onehot;

  swp_axil u_axil (
    .clk        (clk),
    .rstn       (rstn),
    .awvalid    (awvalid),
    .awready_ff (awready),
    .awaddr     (awaddr),
    .wvalid     (wvalid),
    .wready_ff  (wready),
    .wdata      (wdata),
    .wstrb      (wstrb),
    .bvalid_ff  (bvalid),
    .bready     (bready),
    .bresp_ff   (bresp),
    .arvalid    (arvalid),
    .arready_ff (arready),
    .araddr     (araddr),
    .rvalid_ff  (rvalid),
    .rready     (rready),
    .rdata_ff   (rdata),
    .rresp_ff   (rresp),
    .rb         (rb_if)
  );

  swp_pin_mux u_pins (
    .clk            (clk),
    .rstn           (rstn),
    .qe             (qe_ff),
    .dl2_in         (dl2_in),
    .dl3_in         (dl3_in),
    .quad_dout      (quad_dout),
    .quad_doe       (quad_doe),
    .wp_level_ff    (wp_level),
    .hold_active_ff (hold_active),
    .dl2_out_ff     (dl2_out),
    .dl3_out_ff     (dl3_out),
    .dl2_oe_n_ff    (dl2_oe_n),
    .dl3_oe_n_ff    (dl3_oe_n)
  );

  assign pmode     = swp_pmode_t'({pm_hi_ff, pm_lo_ff});
  assign cmd_wr    = rb_if.wr_stb && rb_if.wr_addr == SWP_CMD_OFS;
  assign stat_wr   = rb_if.wr_stb && rb_if.wr_addr == SWP_STAT_OFS;
  assign sec_wr    = rb_if.wr_stb && rb_if.wr_addr == SWP_SEC_OFS;
  assign pwr_cycle = cmd_wr && rb_if.wr_data[SWP_CMD_PWR_CYC];

  // Protect mode and pin level decide whether a status write lands
  assign sr_ok = swp_sr_write_ok(pmode, wel_ff, wp_level);

  // Security region program or erase: index 1 to 3, 0 is not a region
  assign sec_idx    = rb_if.wr_data[1:0];
  assign sec_onehot = (sec_idx == 2'h0) ? 3'h0 :
                      3'(3'h1 << (sec_idx - 2'h1));
  assign sec_hit    = |(sec_onehot & lock_ff);
  assign sec_ok     = wel_ff && sec_idx != 2'h0 && !sec_hit;

  assign quad_mode = qe_ff;
  assign sec_lock  = lock_ff;
  assign sec_prog  = sec_prog_ff;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wel_ff <= 1'b0;
    end else if (pwr_cycle) begin
      wel_ff <= 1'b0;
    end else if ((stat_wr && sr_ok) || (sec_wr && sec_ok)) begin
      // Latch is used up by each operation it enabled
      wel_ff <= 1'b0;
    end else if (cmd_wr && rb_if.wr_data[SWP_CMD_SET_WEL]) begin
      wel_ff <= 1'b1;
    end else if (cmd_wr && rb_if.wr_data[SWP_CMD_CLR_WEL]) begin
      wel_ff <= 1'b0;
    end
  end

  // Reset here stands for factory state; power cycles are a command
  always_ff @(posedge clk) begin
    if (!rstn) begin
      {pm_hi_ff, pm_lo_ff} <= SWP_PM_RST;
    end else if (pwr_cycle && pmode == SWP_PM_LOCKDOWN) begin
      {pm_hi_ff, pm_lo_ff} <= SWP_PM_RST;
    end else if (stat_wr && sr_ok) begin
      pm_hi_ff <= rb_if.wr_data[SWP_PM_HI_BIT];
      pm_lo_ff <= rb_if.wr_data[SWP_PM_LO_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      qe_ff <= SWP_QE_RST;
    end else if (stat_wr && sr_ok) begin
      qe_ff <= rb_if.wr_data[SWP_QE_BIT];
    end
  end

  // Lock bits only ever accumulate ones
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lock_ff <= SWP_LOCK_RST;
    end else if (stat_wr && sr_ok) begin
      lock_ff <= lock_ff |
                 rb_if.wr_data[SWP_LOCK_MSB:SWP_LOCK_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sec_prog_ff <= 3'h0;
    end else if (sec_wr && sec_ok) begin
      sec_prog_ff <= sec_onehot;
    end else begin
      sec_prog_ff <= 3'h0;
    end
  end

  // Outcome flags of the last attempt, overwritten by the next one
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sr_rej_ff <= 1'b0;
      sr_acc_ff <= 1'b0;
    end else if (stat_wr) begin
      sr_rej_ff <= !sr_ok;
      sr_acc_ff <= sr_ok;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sec_rej_ff <= 1'b0;
      sec_acc_ff <= 1'b0;
    end else if (sec_wr) begin
      sec_rej_ff <= !sec_ok;
      sec_acc_ff <= sec_ok;
    end
  end

  always_comb begin
    rb_if.rd_data = 32'h0000_0000;
    unique case (rb_if.rd_addr)
      SWP_CMD_OFS: begin
        rb_if.rd_data[SWP_CMD_SET_WEL] = wel_ff;
      end
      SWP_STAT_OFS: begin
        rb_if.rd_data[SWP_WEL_BIT]   = wel_ff;
        rb_if.rd_data[SWP_PM_LO_BIT] = pm_lo_ff;
        rb_if.rd_data[SWP_PM_HI_BIT] = pm_hi_ff;
        rb_if.rd_data[SWP_QE_BIT]    = qe_ff;
        rb_if.rd_data[SWP_LOCK_MSB:SWP_LOCK_LSB] = lock_ff;
      end
      SWP_EVT_OFS: begin
        rb_if.rd_data[SWP_EVT_SR_REJ]  = sr_rej_ff;
        rb_if.rd_data[SWP_EVT_SR_ACC]  = sr_acc_ff;
        rb_if.rd_data[SWP_EVT_SEC_REJ] = sec_rej_ff;
        rb_if.rd_data[SWP_EVT_SEC_ACC] = sec_acc_ff;
        rb_if.rd_data[SWP_EVT_WP_LVL]  = wp_level;
      end
      default: begin
        rb_if.rd_data = 32'h0000_0000;
      end
    endcase
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_soft_accept: assert property (
    stat_wr && pmode == SWP_PM_SOFT && wel_ff |=>
      {pm_hi_ff, pm_lo_ff} ==
      $past(rb_if.wr_data[SWP_PM_HI_BIT:SWP_PM_LO_BIT]) && sr_acc_ff)
    else $error("status write refused in software mode");

  a_hw_reject: assert property (
    stat_wr && pmode == SWP_PM_HW && !wp_level |=>
      sr_rej_ff && $stable({pm_hi_ff, pm_lo_ff, qe_ff, lock_ff}))
    else $error("status write taken with protect pin low");

  a_hw_unprot: assert property (
    stat_wr && pmode == SWP_PM_HW && wp_level && wel_ff |=>
      sr_acc_ff && !wel_ff)
    else $error("status write refused with protect pin high");

  a_lockdown_hold: assert property (
    stat_wr && pmode == SWP_PM_LOCKDOWN |=>
      sr_rej_ff && $stable({qe_ff, lock_ff}) && pmode == SWP_PM_LOCKDOWN)
    else $error("status write taken during lock-down");

  a_pwr_release: assert property (
    pwr_cycle && pmode == SWP_PM_LOCKDOWN |=>
      pmode == SWP_PM_SOFT && !wel_ff)
    else $error("power cycle did not release lock-down");

  a_otp_forever: assert property (
    pmode == SWP_PM_OTP |=> pmode == SWP_PM_OTP ##1 pmode == SWP_PM_OTP)
    else $error("permanent protect mode left");

  a_quad_pins: assert property (
    qe_ff |=> !hold_active && wp_level)
    else $error("protect or hold still active in quad mode");

  a_single_pins: assert property (
    !qe_ff |=> dl2_oe_n && dl3_oe_n)
    else $error("data lines driven with quad disabled");

  a_lock_sticky: assert property (
    (lock_ff & $past(lock_ff)) == $past(lock_ff))
    else $error("security lock bit cleared");

  a_lock_set: assert property (
    stat_wr && sr_ok |=> lock_ff ==
      ($past(lock_ff) | $past(rb_if.wr_data[SWP_LOCK_MSB:SWP_LOCK_LSB])))
    else $error("lock bits not merged from status write");

  a_sec_locked: assert property (
    sec_wr && sec_hit |=> sec_prog_ff == 3'h0 && sec_rej_ff)
    else $error("locked security region accepted an operation");

  // Flags of the other kind of attempt keep their old value
  a_wel_needed: assert property (
    (stat_wr || sec_wr) && !wel_ff |=>
      !($past(stat_wr) && sr_acc_ff) && !($past(sec_wr) && sec_acc_ff) &&
      sec_prog_ff == 3'h0 ##1 sec_prog_ff == 3'h0)
    else $error("operation taken without write enable");

  a_lock_default: assert property (
    $past(!rstn) |-> lock_ff == SWP_LOCK_RST && !qe_ff)
    else $error("lock or quad bits not at default after reset");

  a_sec_grant: assert property (
    sec_wr && sec_ok |=>
      sec_prog_ff == $past(sec_onehot) && $onehot(sec_prog_ff) && !wel_ff)
    else $error("unlocked security region not granted");

  a_qe_store: assert property (
    stat_wr && sr_ok |=> qe_ff == $past(rb_if.wr_data[SWP_QE_BIT]))
    else $error("quad enable not stored from status write");

  a_pm_store: assert property (
    stat_wr && sr_ok |=>
      {pm_hi_ff, pm_lo_ff} ==
      $past(rb_if.wr_data[SWP_PM_HI_BIT:SWP_PM_LO_BIT]))
    else $error("protect mode not stored from status write");

  a_otp_reject: assert property (
    stat_wr && pmode == SWP_PM_OTP |=>
      sr_rej_ff && $stable({qe_ff, lock_ff}))
    else $error("status write taken in permanent mode");

  a_wp_follow: assert property (
    !qe_ff |=> wp_level == $past(dl2_in))
    else $error("protect level does not follow its pin");

  a_hold_follow: assert property (
    !qe_ff |=> hold_active == !$past(dl3_in))
    else $error("hold does not follow its pin");

  a_quad_drive: assert property (
    qe_ff && quad_doe |=> !dl2_oe_n && !dl3_oe_n)
    else $error("data lines not driven in quad mode");

  a_pwr_wel: assert property (
    pwr_cycle |=> !wel_ff)
    else $error("latch survived a power cycle");

  c_hw_reject:  cover property (stat_wr && pmode == SWP_PM_HW && !wp_level);
  c_sr_write:   cover property (stat_wr && sr_ok);
  c_lockdown:   cover property (pwr_cycle && pmode == SWP_PM_LOCKDOWN);
  c_sec_prog:   cover property (sec_wr && sec_ok);
  c_quad_on:    cover property ($rose(qe_ff));
endmodule
